// File: hdl/asfg_status.sv
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "asfg_map.svh"

// Notes on behaviour
// - register holds ALU result flags, instruction updated
// - instructions read or write it like any register
// - ALU flags override explicit write of flags
// - clearing it sets zero, keeps others
// - subtraction: carry flags mean no borrow
module asfg_status
  import asfg_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic [`ASFG_ADDR_W-1:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  input wire logic exec_valid_in,
  input wire asfg_op_t exec_op_in,
  input wire logic [7:0] exec_file_in,
  input wire logic [7:0] exec_wreg_in,
  input wire logic [2:0] exec_bit_in,
  input wire logic exec_src_status_in,
  input wire logic exec_dst_status_in,
  output logic [7:0] exec_result_out,
  output logic exec_done_out,
  output logic [4:0] status_flags_out
);

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  asfg_flags_t status_r;
  asfg_flags_t status_nxt;
  asfg_flags_t alu_flags;
  asfg_flags_t alu_affect;
  logic [7:0] operand;
  logic [7:0] alu_result;
  logic [7:0] rdata_r;
  logic [7:0] result_r;
  logic done_r;
  logic bus_hit_wr;

  // ----------------------------------------------------------------
  // operand select and ALU
  // ----------------------------------------------------------------
  assign operand = exec_src_status_in ? {{`ASFG_UNUSED_W{1'b0}}, status_r}
                                      : exec_file_in;

  asfg_alu u_alu
  (
    .op_in(exec_op_in),
    .file_in(operand),
    .wreg_in(exec_wreg_in),
    .bit_in(exec_bit_in),
    .carry_in(status_r[`ASFG_BIT_C]),
    .result_out(alu_result),
    .flags_out(alu_flags),
    .affect_out(alu_affect)
  );

  assign bus_hit_wr = reg_wr_in && (reg_addr_in == `ASFG_STATUS_ADDR);

  // ----------------------------------------------------------------
  // status next value; instruction beats a bus write in the same cycle
  // ----------------------------------------------------------------
  always_comb
  begin
    status_nxt = status_r;
    if (exec_valid_in)
    begin
      // flag-affecting op blocks the explicit write of all five bits
      if (exec_dst_status_in && alu_affect == 5'h00)
        status_nxt = alu_result[4:0];
      else
        status_nxt = (status_r & ~alu_affect) | (alu_flags & alu_affect);
    end
    else if (bus_hit_wr)
      status_nxt = reg_wdata_in[4:0];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      status_r <= `ASFG_STATUS_RST;
    else
      status_r <= status_nxt;
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
      rdata_r <= 8'h00;
    else if (reg_rd_in && reg_addr_in == `ASFG_STATUS_ADDR)
      rdata_r <= {{`ASFG_UNUSED_W{1'b0}}, status_r};
    else
      rdata_r <= 8'h00;
  end

  // ----------------------------------------------------------------
  // instruction result
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (srst_in)
    begin
      result_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= exec_valid_in;
      if (exec_valid_in)
        result_r <= alu_result;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign exec_result_out = result_r;
  assign exec_done_out = done_r;
  assign status_flags_out = status_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_sets_zero: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_CLEAR_FILE && exec_dst_status_in
    |=> status_r == ($past(status_r) | 5'h04) && reg_rdata_out[7:5] == 3'h0
  ) else $error("clear of status did not give 000u u1uu");

  a_flags_beat_write: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_dst_status_in
    |=> ((status_r ^ $past(alu_flags)) & $past(alu_affect)) == 5'h00
  ) else $error("explicit write reached an ALU flag bit");

  a_quiet_ops_keep: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && !exec_dst_status_in && exec_op_in inside
      {ASFG_OP_BIT_CLEAR, ASFG_OP_BIT_SET, ASFG_OP_NIBBLE_EXCHANGE,
       ASFG_OP_FILE_TO_FILE_MOVE, ASFG_OP_WREG_TO_FILE_MOVE}
    |=> $stable(status_r)
  ) else $error("flag neutral operation changed flags");

  a_sub_borrow_sense: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_SUB && !exec_src_status_in
    |=> status_r[`ASFG_BIT_C] == ($past(exec_file_in) >= $past(exec_wreg_in))
        && status_r[`ASFG_BIT_DC] == ($past(exec_file_in[3:0]) >= $past(exec_wreg_in[3:0]))
  ) else $error("subtract carry is not inverted borrow");

  a_bus_write_lands: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    reg_wr_in && reg_addr_in == `ASFG_STATUS_ADDR && !exec_valid_in
    ##1 reg_rd_in && reg_addr_in == `ASFG_STATUS_ADDR && !exec_valid_in
    |=> reg_rdata_out == {3'h0, $past(reg_wdata_in[4:0], 2)}
  ) else $error("status write did not read back");

  a_add_zero_flag: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_ADD && !exec_dst_status_in && !exec_src_status_in
    |=> status_r[`ASFG_BIT_Z] == (exec_result_out == 8'h00)
        && status_r[`ASFG_BIT_N] == exec_result_out[7]
  ) else $error("add flags disagree with result");

  a_upper_bits_zero: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    reg_rd_in |=> reg_rdata_out[7:5] == 3'h0
  ) else $error("unused status bits read nonzero");

  a_wreg_move_lands: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_WREG_TO_FILE_MOVE && exec_dst_status_in
    |=> status_r == $past(exec_wreg_in[4:0])
  ) else $error("move into status did not land");

  a_add_carry_out: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_ADD && !exec_src_status_in
    |=> status_r[`ASFG_BIT_C]
        == (({1'b0, $past(exec_file_in)} + {1'b0, $past(exec_wreg_in)}) > 9'h0FF)
  ) else $error("add carry flag wrong");

  a_logic_keeps_carry: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && !exec_dst_status_in
      && exec_op_in inside {ASFG_OP_AND, ASFG_OP_IOR, ASFG_OP_XOR, ASFG_OP_MOVF}
    |=> $stable(status_r[`ASFG_BIT_C]) && $stable(status_r[`ASFG_BIT_DC])
        && $stable(status_r[`ASFG_BIT_OV])
  ) else $error("logic operation touched carry or overflow");

  a_clear_result_zero: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    exec_valid_in && exec_op_in == ASFG_OP_CLEAR_FILE |=> exec_result_out == 8'h00
  ) else $error("clear did not give zero result");

  a_done_one_cycle: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    1'b1 |=> exec_done_out == $past(exec_valid_in)
  ) else $error("done pulse misaligned");

  a_idle_read_zero: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !reg_rd_in |=> reg_rdata_out == 8'h00
  ) else $error("read data without a read strobe");

  a_flags_hold_idle: assert property (
    @(posedge core_clk_in) disable iff (srst_in)
    !exec_valid_in && !bus_hit_wr |=> $stable(status_r)
  ) else $error("flags changed with no update");

endmodule // asfg_status

`default_nettype wire

// File: pkg/asfg_map.svh
`ifndef ASFG_MAP_SVH
`define ASFG_MAP_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ASFG_ADDR_W 12
`define ASFG_STATUS_ADDR 12'hFDB
`define ASFG_STATUS_RST 5'h00

// ----------------------------------------------------------------
// flag field positions
// ----------------------------------------------------------------
`define ASFG_BIT_C 0
`define ASFG_BIT_DC 1
`define ASFG_BIT_Z 2
`define ASFG_BIT_OV 3
`define ASFG_BIT_N 4
`define ASFG_FLAG_W 5
`define ASFG_UNUSED_W 3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ASFG_RD_LAT 1

`endif

// File: pkg/asfg_pkg.sv
package asfg_pkg;

  typedef enum logic [3:0]
  {
    ASFG_OP_ADD,
    ASFG_OP_ADDC,
    ASFG_OP_SUB,
    ASFG_OP_SUBB,
    ASFG_OP_INC,
    ASFG_OP_DEC,
    ASFG_OP_AND,
    ASFG_OP_IOR,
    ASFG_OP_XOR,
    ASFG_OP_MOVF,
    ASFG_OP_CLEAR_FILE,
    ASFG_OP_BIT_CLEAR,
    ASFG_OP_BIT_SET,
    ASFG_OP_NIBBLE_EXCHANGE,
    ASFG_OP_FILE_TO_FILE_MOVE,
    ASFG_OP_WREG_TO_FILE_MOVE
  } asfg_op_t;

  typedef logic [4:0] asfg_flags_t;

endpackage

// File: hdl/asfg_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "asfg_map.svh"

module asfg_alu
  import asfg_pkg::*;
(
  input wire asfg_op_t op_in,
  input wire logic [7:0] file_in,
  input wire logic [7:0] wreg_in,
  input wire logic [2:0] bit_in,
  input wire logic carry_in,
  output logic [7:0] result_out,
  output asfg_flags_t flags_out,
  output asfg_flags_t affect_out
);

  // ----------------------------------------------------------------
  // flag packing
  // ----------------------------------------------------------------
  function automatic asfg_flags_t pack_flags(input logic n, input logic ov,
                                             input logic z, input logic dc,
                                             input logic c);
    asfg_flags_t f;
    f = '0;
    f[`ASFG_BIT_N] = n;
    f[`ASFG_BIT_OV] = ov;
    f[`ASFG_BIT_Z] = z;
    f[`ASFG_BIT_DC] = dc;
    f[`ASFG_BIT_C] = c;
    return f;
  endfunction

  logic [7:0] addend;
  logic cin;
  logic [4:0] low_sum;
  logic [8:0] sum;
  logic [7:0] res;
  logic ov;

  // ----------------------------------------------------------------
  // shared adder; subtraction adds the complement so carry means no borrow
  // ----------------------------------------------------------------
  always_comb
  begin
    addend = wreg_in;
    cin = 1'b0;
    case (op_in)
      ASFG_OP_ADDC: cin = carry_in;
      ASFG_OP_SUB:
      begin
        addend = ~wreg_in;
        cin = 1'b1;
      end
      ASFG_OP_SUBB:
      begin
        addend = ~wreg_in;
        cin = carry_in;
      end
      ASFG_OP_INC:
      begin
        addend = 8'h00;
        cin = 1'b1;
      end
      ASFG_OP_DEC:
      begin
        addend = 8'hFE;
        cin = 1'b1;
      end
      default: ;
    endcase
  end

  assign low_sum = {1'b0, file_in[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  assign sum = {1'b0, file_in} + {1'b0, addend} + {8'h00, cin};
  assign ov = (file_in[7] == addend[7]) && (sum[7] != file_in[7]);

  // ----------------------------------------------------------------
  // result and flags per operation
  // ----------------------------------------------------------------
  always_comb
  begin
    res = file_in;
    flags_out = '0;
    affect_out = '0;
    case (op_in)
      ASFG_OP_ADD, ASFG_OP_ADDC, ASFG_OP_SUB, ASFG_OP_SUBB, ASFG_OP_INC, ASFG_OP_DEC:
      begin
        res = sum[7:0];
        flags_out = pack_flags(sum[7], ov, sum[7:0] == 8'h00, low_sum[4], sum[8]);
        affect_out = 5'h1F;
      end
      ASFG_OP_AND, ASFG_OP_IOR, ASFG_OP_XOR, ASFG_OP_MOVF, ASFG_OP_CLEAR_FILE:
      begin
        if (op_in == ASFG_OP_AND)
          res = file_in & wreg_in;
        else if (op_in == ASFG_OP_IOR)
          res = file_in | wreg_in;
        else if (op_in == ASFG_OP_XOR)
          res = file_in ^ wreg_in;
        else if (op_in == ASFG_OP_CLEAR_FILE)
          res = 8'h00;
        flags_out = pack_flags(res[7], 1'b0, res == 8'h00, 1'b0, 1'b0);
        affect_out = pack_flags(op_in != ASFG_OP_CLEAR_FILE, 1'b0, 1'b1, 1'b0, 1'b0);
      end
      ASFG_OP_BIT_CLEAR: res = file_in & ~(8'h01 << bit_in);
      ASFG_OP_BIT_SET: res = file_in | (8'h01 << bit_in);
      ASFG_OP_NIBBLE_EXCHANGE: res = {file_in[3:0], file_in[7:4]};
      ASFG_OP_FILE_TO_FILE_MOVE: res = file_in;
      ASFG_OP_WREG_TO_FILE_MOVE: res = wreg_in;
      default: res = file_in;
    endcase
    result_out = res;
  end

endmodule // asfg_alu

`default_nettype wire

// File: bench/asfg_status_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "asfg_map.svh"

`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end

module asfg_status_test
  import asfg_pkg::*;
;
  logic core_clk_in;
  logic srst_in;
  logic [`ASFG_ADDR_W-1:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic exec_valid_in;
  asfg_op_t exec_op_in;
  logic [7:0] exec_file_in;
  logic [7:0] exec_wreg_in;
  logic [2:0] exec_bit_in;
  logic exec_src_status_in;
  logic exec_dst_status_in;
  logic [7:0] exec_result_out;
  logic exec_done_out;
  logic [4:0] status_flags_out;
  int fail_count;
  int cmp_count;
  localparam logic [11:0] SA = `ASFG_STATUS_ADDR;

  asfg_status dut
  (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .exec_valid_in(exec_valid_in),
    .exec_op_in(exec_op_in),
    .exec_file_in(exec_file_in),
    .exec_wreg_in(exec_wreg_in),
    .exec_bit_in(exec_bit_in),
    .exec_src_status_in(exec_src_status_in),
    .exec_dst_status_in(exec_dst_status_in),
    .exec_result_out(exec_result_out),
    .exec_done_out(exec_done_out),
    .status_flags_out(status_flags_out)
  );

  // ----------------------------------------------------------------
  // clock and access tasks
  // ----------------------------------------------------------------
  initial
  begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK("read data", exp, reg_rdata_out)
  endtask

  task automatic wr_rd(input logic [11:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    `CHK("read after write", exp, reg_rdata_out)
  endtask

  task automatic ex(input asfg_op_t op, input logic [7:0] f, input logic [7:0] w,
                    input logic [2:0] b, input logic src, input logic dst,
                    input logic [7:0] exp_res, input logic [4:0] exp_flg);
    @(posedge core_clk_in);
    exec_op_in <= op;
    exec_file_in <= f;
    exec_wreg_in <= w;
    exec_bit_in <= b;
    exec_src_status_in <= src;
    exec_dst_status_in <= dst;
    exec_valid_in <= 1'b1;
    @(posedge core_clk_in);
    exec_valid_in <= 1'b0;
    #1;
    `CHK("done", 1'b1, exec_done_out)
    `CHK("result", exp_res, exec_result_out)
    `CHK("flags", exp_flg, status_flags_out)
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (5000) @(posedge core_clk_in);
    fail_count++;
    complete_run;
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    srst_in = 1'b1;
    reg_addr_in = 12'h000;
    reg_wdata_in = 8'h00;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    exec_valid_in = 1'b0;
    exec_op_in = ASFG_OP_ADD;
    exec_file_in = 8'h00;
    exec_wreg_in = 8'h00;
    exec_bit_in = 3'h0;
    exec_src_status_in = 1'b0;
    exec_dst_status_in = 1'b0;
    repeat (10) @(posedge core_clk_in);
    srst_in <= 1'b0;
    rd(SA, 8'h00);
    wr(SA, 8'hFF);
    rd(SA, 8'h1F);
    wr(12'hFDA, 8'h00);
    rd(SA, 8'h1F);
    rd(12'hFDA, 8'h00);
    // clear of the flag register only raises zero
    wr(SA, 8'h0B);
    ex(ASFG_OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1, 8'h00, 5'h0F);
    rd(SA, 8'h0F);
    // subtraction with borrow meaning
    ex(ASFG_OP_SUB, 8'h05, 8'h03, 3'h0, 1'b0, 1'b0, 8'h02, 5'h03);
    ex(ASFG_OP_SUB, 8'h03, 8'h05, 3'h0, 1'b0, 1'b0, 8'hFE, 5'h10);
    // alu flags win over the explicit write
    ex(ASFG_OP_ADD, 8'h7F, 8'h01, 3'h0, 1'b0, 1'b1, 8'h80, 5'h1A);
    // operations that leave the flags alone write through
    ex(ASFG_OP_BIT_CLEAR, 8'h00, 8'h00, 3'h3, 1'b1, 1'b1, 8'h12, 5'h12);
    ex(ASFG_OP_BIT_SET, 8'h00, 8'h00, 3'h0, 1'b1, 1'b1, 8'h13, 5'h13);
    ex(ASFG_OP_NIBBLE_EXCHANGE, 8'h00, 8'h00, 3'h0, 1'b1, 1'b1, 8'h31, 5'h11);
    ex(ASFG_OP_WREG_TO_FILE_MOVE, 8'h00, 8'h0C, 3'h0, 1'b0, 1'b1, 8'h0C, 5'h0C);
    ex(ASFG_OP_FILE_TO_FILE_MOVE, 8'hE5, 8'h00, 3'h0, 1'b0, 1'b1, 8'hE5, 5'h05);
    // flag register as a source operand
    ex(ASFG_OP_FILE_TO_FILE_MOVE, 8'hAA, 8'h00, 3'h0, 1'b1, 1'b0, 8'h05, 5'h05);
    rd(SA, 8'h05);
    // arithmetic and logic updates with a file destination
    ex(ASFG_OP_ADD, 8'hFF, 8'h01, 3'h0, 1'b0, 1'b0, 8'h00, 5'h07);
    ex(ASFG_OP_ADDC, 8'h10, 8'h20, 3'h0, 1'b0, 1'b0, 8'h31, 5'h00);
    ex(ASFG_OP_SUBB, 8'h10, 8'h01, 3'h0, 1'b0, 1'b0, 8'h0E, 5'h01);
    ex(ASFG_OP_INC, 8'h7F, 8'h00, 3'h0, 1'b0, 1'b0, 8'h80, 5'h1A);
    ex(ASFG_OP_DEC, 8'h00, 8'h00, 3'h0, 1'b0, 1'b0, 8'hFF, 5'h10);
    ex(ASFG_OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0, 1'b0, 8'h00, 5'h04);
    ex(ASFG_OP_IOR, 8'h80, 8'h01, 3'h0, 1'b0, 1'b0, 8'h81, 5'h10);
    ex(ASFG_OP_XOR, 8'h5A, 8'h5A, 3'h0, 1'b0, 1'b0, 8'h00, 5'h04);
    ex(ASFG_OP_MOVF, 8'h80, 8'h00, 3'h0, 1'b0, 1'b0, 8'h80, 5'h10);
    // reset in mid run clears flags and outputs
    @(posedge core_clk_in);
    srst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    #1;
    `CHK("flags after reset", 5'h00, status_flags_out)
    `CHK("result after reset", 8'h00, exec_result_out)
    `CHK("done after reset", 1'b0, exec_done_out)
    // write then read with no gap, upper bits dropped
    wr_rd(SA, 8'hE6, 8'h06);
    repeat (2) @(posedge core_clk_in);
    complete_run;
  end
endmodule // asfg_status_test

`default_nettype wire
